// ===== rtl/afe_ctrl.v
`timescale 1ns/10ps
`include "afe_ctrl_defs.vh"
// Front-end configuration, serial register port and result path.
module afe_ctrl (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Serial port pins
  input wire cs_n_i,
  input wire sclk_i,
  input wire din_i,
  output reg data_out_ready_pin_o,
  output reg dout_oe_n_o,
  // Conversion trigger pin and system clock sources
  input wire start_pin_i,
  input wire osc_clk_i,
  input wire ext_clk_i,
  // Modulator result stream
  input wire raw_valid_i,
  input wire [`RES_W-1:0] raw_result_i,
  output reg raw_ready_o,
  output reg conv_run_o,
  // Multiplexer controls
  output reg [3:0] positive_channel_sel_o,
  output reg [3:0] negative_channel_sel_o,
  output reg mid_supply_tie_o,
  output reg [2:0] monitor_sel_o,
  output reg burnout_en_o,
  // Amplifier controls
  output reg amp_powered_o,
  output reg amp_bypass_o,
  output reg [2:0] amp_analog_gain_o,
  // Excitation, bias and general-purpose pins
  output reg [3:0] exc1_route_o,
  output reg [3:0] exc2_route_o,
  output reg [6:0] sensor_bias_voltage_en_o,
  output reg [3:0] gpio_en_o,
  output reg [3:0] gpio_out_o,
  // Clock and filter status
  output reg ext_clk_sel_o,
  output reg reject_50_o,
  output reg reject_60_o
);

  // Analog gain code clamped to 32; remaining factor goes to digital shift.
  function [2:0] analog_gain;
    input [2:0] code;
    begin
      analog_gain = (code > `GAIN_CODE_32) ? `GAIN_CODE_32 : code;
    end
  endfunction

  // Scales a signed result by a power of two with saturation.
  function [`RES_W-1:0] scale_sat;
    input [`RES_W-1:0] val;
    input [1:0] sh;
    reg [`RES_W+1:0] wide;
    reg [`RES_W+1:0] ext;
    begin
      wide = {{2{val[`RES_W-1]}}, val};
      ext = wide << sh;
      if (ext[`RES_W+1:`RES_W-1] == 3'h0 || ext[`RES_W+1:`RES_W-1] == 3'h7)
        scale_sat = ext[`RES_W-1:0];
      else if (ext[`RES_W+1])
        scale_sat = `RES_MIN;
      else
        scale_sat = `RES_MAX;
    end
  endfunction

  // Register file.
  reg [7:0] chan_sel_ff;
  reg [7:0] gain_ff;
  reg [7:0] rate_ff;
  reg [7:0] exc_route_ff;
  reg [7:0] monitor_ff;
  reg [7:0] bias_ff;
  reg [7:0] gpio_ff;

  // Synchronisers for pins and clocks from outside.
  reg [1:0] cs_sync_ff;
  reg [1:0] sclk_sync_ff;
  reg [1:0] din_sync_ff;
  reg [1:0] start_sync_ff;
  reg [1:0] osc_sync_ff;
  reg [1:0] ext_sync_ff;
  reg sclk_d_ff;
  reg start_d_ff;
  reg sys_d_ff;

  // Serial engine state.
  reg [4:0] bit_cnt_ff;
  reg [7:0] rx_ff;
  reg [7:0] cmd_ff;
  reg [15:0] tx_ff;
  reg tx_act_ff;
  reg start_cmd_ff;

  // Break-before-make state.
  reg brk_ff;
  reg [1:0] brk_cnt_ff;

  // Result path.
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`RES_W-1:0] fifo_out_data;
  reg fifo_pop;
  wire push;
  wire [`RES_W-1:0] scaled;
  wire sclk_rise;
  wire sclk_fall;
  wire start_rise;
  wire sys_sel;
  wire sys_rise;
  wire [7:0] byte_in;
  reg [7:0] rd_val;
  wire [2:0] dig_shift;
  wire [7:0] chan_rst;

  // Reset image of the channel register, split into its two select fields.
  assign chan_rst = `RST_CHAN_SEL;

  assign sclk_rise = sclk_sync_ff[1] & ~sclk_d_ff;
  assign sclk_fall = ~sclk_sync_ff[1] & sclk_d_ff;
  assign start_rise = start_sync_ff[1] & ~start_d_ff;
  assign byte_in = {rx_ff[6:0], din_sync_ff[1]};

  // The selected system clock paces the break interval.
  assign sys_sel = rate_ff[`RATE_CLK_SEL] ? ext_sync_ff[1] : osc_sync_ff[1];
  assign sys_rise = sys_sel & ~sys_d_ff;

  // Results take the digital part of gain 64 and 128 only with the amplifier on.
  assign dig_shift = gain_ff[`GAIN_MSB:`GAIN_LSB] - analog_gain(gain_ff[`GAIN_MSB:`GAIN_LSB]);
  assign scaled = (gain_ff[`AMP_EN_MSB:`AMP_EN_LSB] == `AMP_BYPASS) ? raw_result_i :
    scale_sat(raw_result_i, dig_shift[1:0]);
  assign push = raw_valid_i & conv_run_o;

  // Read multiplexer; unmapped addresses read as zero.
  always @*
  begin
    case (byte_in[3:0])
      `ADDR_CHAN_SEL: rd_val = chan_sel_ff;
      `ADDR_GAIN: rd_val = gain_ff;
      `ADDR_RATE: rd_val = rate_ff;
      `ADDR_EXC_ROUTE: rd_val = exc_route_ff;
      `ADDR_MONITOR: rd_val = monitor_ff;
      `ADDR_BIAS: rd_val = bias_ff;
      `ADDR_GPIO: rd_val = gpio_ff;
      default: rd_val = 8'h00;
    endcase
  end

  // Two-stage synchronisers and edge history.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cs_sync_ff <= 2'h3;
      sclk_sync_ff <= 2'h0;
      din_sync_ff <= 2'h0;
      start_sync_ff <= 2'h0;
      osc_sync_ff <= 2'h0;
      ext_sync_ff <= 2'h0;
      sclk_d_ff <= 1'b0;
      start_d_ff <= 1'b0;
      sys_d_ff <= 1'b0;
    end
    else
    begin
      cs_sync_ff <= {cs_sync_ff[0], cs_n_i};
      sclk_sync_ff <= {sclk_sync_ff[0], sclk_i};
      din_sync_ff <= {din_sync_ff[0], din_i};
      start_sync_ff <= {start_sync_ff[0], start_pin_i};
      osc_sync_ff <= {osc_sync_ff[0], osc_clk_i};
      ext_sync_ff <= {ext_sync_ff[0], ext_clk_i};
      sclk_d_ff <= sclk_sync_ff[1];
      start_d_ff <= start_sync_ff[1];
      sys_d_ff <= sys_sel;
    end
  end

  // Serial engine: sample on falling edge, shift out on rising edge.
  always @(posedge clk_i)
  begin
    fifo_pop <= 1'b0;
    if (rst_i)
    begin
      bit_cnt_ff <= 5'h00;
      rx_ff <= 8'h00;
      cmd_ff <= 8'h00;
      tx_ff <= 16'h0000;
      tx_act_ff <= 1'b0;
      start_cmd_ff <= 1'b0;
      chan_sel_ff <= `RST_CHAN_SEL;
      gain_ff <= `RST_GAIN;
      rate_ff <= `RST_RATE;
      exc_route_ff <= `RST_EXC_ROUTE;
      monitor_ff <= `RST_MONITOR;
      bias_ff <= `RST_BIAS;
      gpio_ff <= `RST_GPIO;
      fifo_pop <= 1'b0;
    end
    else if (cs_sync_ff[1])
    begin
      // A deselected port restarts its framing.
      bit_cnt_ff <= 5'h00;
      tx_act_ff <= 1'b0;
      start_cmd_ff <= 1'b0;
    end
    else
    begin
      // Chip select held low keeps byte framing running from reset.
      start_cmd_ff <= 1'b0;
      if (sclk_rise && tx_act_ff)
        tx_ff <= {tx_ff[14:0], 1'b0};
      if (sclk_fall)
      begin
        rx_ff <= byte_in;
        bit_cnt_ff <= bit_cnt_ff + 1'b1;
        if (bit_cnt_ff == `BIT_CMD_END)
        begin
          cmd_ff <= byte_in;
          case (byte_in[7:6])
            `CMD_RREG:
            begin
              tx_ff <= {rd_val, 8'h00};
              tx_act_ff <= 1'b1;
            end
            `CMD_RDATA:
            begin
              tx_ff <= fifo_out_valid ? fifo_out_data : 16'h0000;
              tx_act_ff <= 1'b1;
              fifo_pop <= fifo_out_valid;
            end
            `CMD_START:
            begin
              start_cmd_ff <= 1'b1;
              bit_cnt_ff <= 5'h00;
            end
            default:
            begin
              tx_act_ff <= 1'b0;
            end
          endcase
        end
        else if (bit_cnt_ff == `BIT_REG_END && cmd_ff[7:6] != `CMD_RDATA)
        begin
          bit_cnt_ff <= 5'h00;
          tx_act_ff <= 1'b0;
          if (cmd_ff[7:6] == `CMD_WREG)
          begin
            case (cmd_ff[3:0])
              `ADDR_CHAN_SEL: chan_sel_ff <= byte_in;
              `ADDR_GAIN: gain_ff <= byte_in;
              `ADDR_RATE: rate_ff <= byte_in;
              `ADDR_EXC_ROUTE: exc_route_ff <= byte_in;
              `ADDR_MONITOR: monitor_ff <= byte_in;
              `ADDR_BIAS: bias_ff <= {1'b0, byte_in[`BIAS_MSB:0]};
              `ADDR_GPIO: gpio_ff <= byte_in;
              default: cmd_ff <= cmd_ff;
            endcase
          end
        end
        else if (bit_cnt_ff == `BIT_DATA_END)
        begin
          bit_cnt_ff <= 5'h00;
          tx_act_ff <= 1'b0;
        end
      end
    end
  end

  // Shared output pin: ready flag between transfers, data during them.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      data_out_ready_pin_o <= 1'b1;
      dout_oe_n_o <= 1'b1;
    end
    else
    begin
      dout_oe_n_o <= cs_sync_ff[1];
      if (tx_act_ff)
        data_out_ready_pin_o <= tx_ff[15];
      else
        data_out_ready_pin_o <= ~fifo_out_valid;
    end
  end

  // Break-before-make: hold mid-supply for two selected-clock periods.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      brk_ff <= 1'b0;
      brk_cnt_ff <= 2'h0;
      positive_channel_sel_o <= chan_rst[`POS_SEL_MSB:`POS_SEL_LSB];
      negative_channel_sel_o <= chan_rst[`NEG_SEL_MSB:`NEG_SEL_LSB];
      mid_supply_tie_o <= 1'b0;
    end
    else if (chan_sel_ff != {positive_channel_sel_o, negative_channel_sel_o} && !brk_ff)
    begin
      brk_ff <= 1'b1;
      brk_cnt_ff <= 2'h0;
      mid_supply_tie_o <= 1'b1;
    end
    else if (brk_ff && sys_rise)
    begin
      if (brk_cnt_ff == `BRK_PERIODS - 1'b1)
      begin
        brk_ff <= 1'b0;
        mid_supply_tie_o <= 1'b0;
        positive_channel_sel_o <= chan_sel_ff[`POS_SEL_MSB:`POS_SEL_LSB];
        negative_channel_sel_o <= chan_sel_ff[`NEG_SEL_MSB:`NEG_SEL_LSB];
      end
      else
        brk_cnt_ff <= brk_cnt_ff + 1'b1;
    end
  end

  // Static configuration outputs.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      monitor_sel_o <= 3'h0;
      burnout_en_o <= 1'b0;
      amp_powered_o <= 1'b0;
      amp_bypass_o <= 1'b1;
      amp_analog_gain_o <= 3'h0;
      exc1_route_o <= 4'hF;
      exc2_route_o <= 4'hF;
      sensor_bias_voltage_en_o <= 7'h00;
      gpio_en_o <= 4'h0;
      gpio_out_o <= 4'h0;
      ext_clk_sel_o <= 1'b0;
      reject_50_o <= 1'b0;
      reject_60_o <= 1'b0;
    end
    else
    begin
      // Codes: short, temperature, analog supply / 4, digital supply / 4.
      monitor_sel_o <= monitor_ff[`MON_MSB:`MON_LSB];
      burnout_en_o <= monitor_ff[`MON_BURNOUT];
      // Only code 00 bypasses; reserved codes are never written by the host.
      amp_powered_o <= gain_ff[`AMP_EN_MSB:`AMP_EN_LSB] != `AMP_BYPASS;
      amp_bypass_o <= gain_ff[`AMP_EN_MSB:`AMP_EN_LSB] == `AMP_BYPASS;
      amp_analog_gain_o <= analog_gain(gain_ff[`GAIN_MSB:`GAIN_LSB]);
      exc1_route_o <= exc_route_ff[3:0];
      exc2_route_o <= exc_route_ff[7:4];
      sensor_bias_voltage_en_o <= bias_ff[`BIAS_MSB:0];
      gpio_en_o <= gpio_ff[`GPIO_EN_MSB:`GPIO_EN_LSB];
      gpio_out_o <= gpio_ff[`GPIO_OUT_MSB:`GPIO_OUT_LSB];
      ext_clk_sel_o <= rate_ff[`RATE_CLK_SEL];
      // Line rejection follows the programmed rate.
      reject_50_o <= rate_ff[`RATE_MSB:`RATE_LSB] <= `RATE_50;
      reject_60_o <= rate_ff[`RATE_MSB:`RATE_LSB] <= `RATE_20 &&
        rate_ff[`RATE_MSB:`RATE_LSB] != `RATE_16P6 ||
        rate_ff[`RATE_MSB:`RATE_LSB] == `RATE_60;
    end
  end

  // Conversion control: pin or command starts, single-shot stops after one result.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      conv_run_o <= 1'b0;
      raw_ready_o <= 1'b0;
    end
    else
    begin
      // Drop ready for a cycle after each accept so a late full flag loses no result.
      raw_ready_o <= fifo_in_ready & ~(push & raw_ready_o);
      if (start_rise || start_cmd_ff)
        conv_run_o <= 1'b1;
      else if (push && raw_ready_o && rate_ff[`RATE_SINGLE])
        conv_run_o <= 1'b0;
    end
  end

  // Result buffer between modulator and serial port.
  result_fifo #(
    .W(`RES_W),
    .D(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push & raw_ready_o),
    .in_ready_o(fifo_in_ready),
    .in_data_i(scaled),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

endmodule

// ===== rtl/afe_ctrl_defs.vh
// How it works
// - Positive and negative amplifier inputs each chosen by a 4-bit field at 0x02.
// - The common input is selectable on either side like any other input.
// - Any channel change ties amplifier inputs to mid-supply for two clock periods first.
// - A monitor code shorts both amplifier inputs together at mid-supply.
// - Monitor codes measure analog supply difference over four and digital supply over four.
// - A monitor code connects the die temperature sensor to the converter.
// - Burn-out current sources act on the inputs currently selected for conversion.
// - Gain field bits [2:0] at 0x03 decode to gains 1 through 128 in binary steps.
// - Amplifier-enable code 00 powers down and bypasses; 01 enables the amplifier.
// - Enabled gain 64 or 128 runs the amplifier at 32 and scales digitally.
// - The four highest-numbered analog inputs may serve as general-purpose pins.
// - Bias voltage may be applied only to inputs zero to five and the common input.
// - Both excitation current sources route to any analog input pin.
// - Filter rejects both line frequencies at rate codes 0 to 2 and 4, 50 Hz alone at 3 and 5, 60 Hz alone at 6, neither above 6.
// - One output pin signals new data ready and shifts out data.
// - Continuous or single-shot conversion mode is selected by programming.
// - The system clock is the internal oscillator or the external clock pin.
// - A clock select bit in the data rate register picks the system clock.
`ifndef AFE_CTRL_DEFS_VH
`define AFE_CTRL_DEFS_VH

// Register offsets.
`define ADDR_CHAN_SEL 4'h2
`define ADDR_GAIN 4'h3
`define ADDR_RATE 4'h4
`define ADDR_EXC_ROUTE 4'h7
`define ADDR_MONITOR 4'h9
`define ADDR_BIAS 4'hD
`define ADDR_GPIO 4'hE

// Reset values.
`define RST_CHAN_SEL 8'h01
`define RST_GAIN 8'h00
`define RST_RATE 8'h04
`define RST_EXC_ROUTE 8'hFF
`define RST_MONITOR 8'h00
`define RST_BIAS 8'h00
`define RST_GPIO 8'h00

// Field positions.
`define POS_SEL_MSB 7
`define POS_SEL_LSB 4
`define NEG_SEL_MSB 3
`define NEG_SEL_LSB 0
`define GAIN_MSB 2
`define GAIN_LSB 0
`define AMP_EN_MSB 6
`define AMP_EN_LSB 5
`define RATE_MSB 3
`define RATE_LSB 0
`define RATE_CLK_SEL 6
`define RATE_SINGLE 5
`define MON_MSB 2
`define MON_LSB 0
`define MON_BURNOUT 3
`define BIAS_MSB 6
`define GPIO_EN_MSB 7
`define GPIO_EN_LSB 4
`define GPIO_OUT_MSB 3
`define GPIO_OUT_LSB 0

// Codes.
`define AMP_BYPASS 2'h0
`define GAIN_CODE_32 3'h5
`define MON_SHORT 3'h1
`define MON_TEMP 3'h2
`define MON_AVDD4 3'h3
`define MON_DVDD4 3'h4
`define RATE_16P6 4'h3
`define RATE_20 4'h4
`define RATE_50 4'h5
`define RATE_60 4'h6

// Serial command classes in bits [7:6] of the first byte.
`define CMD_RREG 2'h0
`define CMD_WREG 2'h1
`define CMD_RDATA 2'h2
`define CMD_START 2'h3

// Serial bit counts at which a frame phase ends.
`define BIT_CMD_END 5'h07
`define BIT_REG_END 5'h0F
`define BIT_DATA_END 5'h17

// Break-before-make length in system clock periods.
`define BRK_PERIODS 2'h2

// Result path.
`define RES_W 16
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define RES_MAX 16'h7FFF
`define RES_MIN 16'h8000

`endif

// ===== rtl/result_fifo.v
`timescale 1ns/10ps
// Synchronous FIFO with registered full and empty flags.
module result_fifo #(
  parameter W = 16,
  parameter D = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  // Drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);

  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  reg full_ff;
  reg empty_ff;
  wire push;
  wire pop;
  reg [AW:0] nxt_count;

  // Handshakes on both sides.
  assign push = in_valid_i & ~full_ff;
  assign pop = out_ready_i & ~empty_ff;
  assign in_ready_o = ~full_ff;
  assign out_valid_o = ~empty_ff;
  assign out_data_o = mem[rd_ptr_ff];

  // Next fill level.
  always @*
  begin
    nxt_count = count_ff;
    if (push && !pop)
      nxt_count = count_ff + 1'b1;
    else if (pop && !push)
      nxt_count = count_ff - 1'b1;
  end

  // Storage write.
  always @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr_ff] <= in_data_i;
  end

  // Pointers and flags.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
      full_ff <= 1'b0;
      empty_ff <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == D - 1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == D - 1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      count_ff <= nxt_count;
      full_ff <= (nxt_count == D);
      empty_ff <= (nxt_count == {(AW+1){1'b0}});
    end
  end

endmodule

// ===== verif/afe_ctrl_checker.sv
`timescale 1ns/10ps
`include "afe_ctrl_defs.vh"
// Temporal checks on the front-end controls and the shared result pin.
module afe_ctrl_checker (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Serial and result path
  input wire cs_n_i,
  input wire raw_valid_i,
  input wire raw_ready_o,
  input wire conv_run_o,
  input wire data_out_ready_pin_o,
  input wire dout_oe_n_o,
  // Front-end controls
  input wire [3:0] positive_channel_sel_o,
  input wire [3:0] negative_channel_sel_o,
  input wire mid_supply_tie_o,
  input wire [2:0] monitor_sel_o,
  input wire amp_powered_o,
  input wire amp_bypass_o,
  input wire [2:0] amp_analog_gain_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Break-before-make: selects move only as the tie ends, after a bounded interval.
  sel_move_a: assert property (
    !$stable({positive_channel_sel_o, negative_channel_sel_o}) |-> $past(mid_supply_tie_o))
    else $error("select moved outside the tie");
  tie_min_a: assert property (
    $rose(mid_supply_tie_o) |-> mid_supply_tie_o [*4])
    else $error("tie too short");
  tie_end_a: assert property (
    $rose(mid_supply_tie_o) |-> ##[4:60] !mid_supply_tie_o)
    else $error("tie too long");
  // Amplifier mode, analog gain limit and monitor code range.
  amp_mode_a: assert property (
    amp_bypass_o == !amp_powered_o)
    else $error("bypass and power disagree");
  gain_cap_a: assert property (
    amp_powered_o |-> amp_analog_gain_o <= `GAIN_CODE_32)
    else $error("analog gain above 32");
  mon_code_a: assert property (
    monitor_sel_o <= `MON_DVDD4)
    else $error("monitor code out of range");
  // Shared pin: driven only after select, low once a result waits.
  oe_cs_a: assert property (
    $fell(dout_oe_n_o) |-> !$past(cs_n_i, 2))
    else $error("pin driven without select");
  ready_low_a: assert property (
    raw_valid_i && raw_ready_o && conv_run_o && cs_n_i && $past(cs_n_i) && $past(cs_n_i, 2)
    ##1 cs_n_i [*2] |-> !data_out_ready_pin_o)
    else $error("ready level missing");
endmodule

// ===== verif/afe_ctrl_test.sv
`timescale 1ns/10ps
`include "afe_ctrl_defs.vh"
// Self-checking bench for the front-end controller.
module afe_ctrl_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_pin = 1'b0;
  logic osc_clk = 1'b0;
  logic ext_clk = 1'b0;
  logic raw_valid = 1'b0;
  logic [15:0] raw_result = 16'h0000;
  logic rdy;
  logic [31:0] rnd = 32'h9141;
  logic [23:0] rx;
  logic [7:0] mdl [16];
  logic [15:0] q [$];
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int tie_cnt = 0;
  wire cs_n, sclk, din, pin, run, tie, powered, bypass, burn, ext_sel, rj50, rj60, ready;
  wire [3:0] psel, nsel, exc1, exc2, gen, gout;
  wire [2:0] mon, again;
  wire [6:0] bias;
  afe_ctrl dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
    .data_out_ready_pin_o(pin), .dout_oe_n_o(), .start_pin_i(start_pin),
    .osc_clk_i(osc_clk), .ext_clk_i(ext_clk), .raw_valid_i(raw_valid),
    .raw_result_i(raw_result), .raw_ready_o(ready), .conv_run_o(run),
    .positive_channel_sel_o(psel), .negative_channel_sel_o(nsel),
    .mid_supply_tie_o(tie), .monitor_sel_o(mon), .burnout_en_o(burn),
    .amp_powered_o(powered), .amp_bypass_o(bypass), .amp_analog_gain_o(again),
    .exc1_route_o(exc1), .exc2_route_o(exc2), .sensor_bias_voltage_en_o(bias),
    .gpio_en_o(gen), .gpio_out_o(gout), .ext_clk_sel_o(ext_sel),
    .reject_50_o(rj50), .reject_60_o(rj60));
  afe_host_model host_u (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din),
    .pin_i(pin));
  // Bench clock at 25 MHz.
  always #20 clk_i = ~clk_i;
  // System clock sources, tie length count and run limit.
  always @(negedge clk_i)
  begin
    cyc <= cyc + 1;
    osc_clk <= (cyc % 6) < 3;
    ext_clk <= (cyc % 10) < 5;
    if (tie === 1'b1)
      tie_cnt <= tie_cnt + 1;
    if (cyc == 40000)
    begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end
  // Pseudo-random source.
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Expected result after digital scaling, saturated to 16 bits.
  function automatic logic [15:0] scale(logic [15:0] v, int sh);
    int s;
    s = $signed(v) * (1 << sh);
    if (s > 32767)
      s = 32767;
    if (s < -32768)
      s = -32768;
    return s[15:0];
  endfunction
  // Compares one value and counts it.
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register write; only mapped addresses update the model.
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input bit hold = 1'b0);
    host_u.xfer({8'h00, `CMD_WREG, 2'b00, a, d}, 16, hold, rx);
    if (a inside {4'h2, 4'h3, 4'h4, 4'h7, 4'h9, 4'hD, 4'hE})
      mdl[a] = d;
  endtask
  // Reads every address against the model; unmapped ones read zero.
  task automatic rd_all;
    for (int a = 0; a < 16; a++)
    begin
      host_u.xfer({8'h00, `CMD_RREG, 2'b00, a[3:0], 8'h00}, 16, 1'b0, rx);
      chk(rx[7:0], mdl[a]);
    end
  endtask
  // Reset held for ten cycles, then the model returns to reset values.
  task automatic do_reset;
    rst_i = 1'b1;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[2] = `RST_CHAN_SEL;
    mdl[4] = `RST_RATE;
    mdl[7] = `RST_EXC_ROUTE;
  endtask
  // Random channel change; the tie must last at least per cycles and the selects must take the new value.
  task automatic chan(input int per);
    logic [7:0] d;
    rnd = lfsr(rnd);
    d = rnd[7:0];
    if (d == mdl[2])
      d = d ^ 8'h11;
    tie_cnt = 0;
    wr(`ADDR_CHAN_SEL, d);
    for (int n = 0; n < 60 && tie === 1'b1; n++)
      @(negedge clk_i);
    chk(tie_cnt >= per, 1'b1);
    chk({psel, nsel}, d);
  endtask
  // Offers results for 40 cycles; taken ones go to the queue.
  task automatic fill(input int sh);
    @(negedge clk_i);
    rnd = lfsr(rnd);
    raw_result = rnd[15:0];
    raw_valid = 1'b1;
    rdy = ready === 1'b1 && run === 1'b1;
    repeat (40)
    begin
      @(negedge clk_i);
      if (rdy)
      begin
        q.push_back(scale(raw_result, sh));
        rnd = lfsr(rnd);
        raw_result = rnd[15:0];
      end
      rdy = ready === 1'b1 && run === 1'b1;
    end
    raw_valid = 1'b0;
  endtask
  // Reads results back in order, then one more from the empty buffer.
  task automatic drain(input bit hold);
    while (q.size() > 0)
    begin
      host_u.xfer({`CMD_RDATA, 22'h0}, 24, hold, rx);
      chk(rx[15:0], q.pop_front());
    end
    host_u.xfer({`CMD_RDATA, 22'h0}, 24, 1'b0, rx);
    chk(rx[15:0], 16'h0000);
  endtask
  // Verdict and end of run.
  task automatic wrap_up;
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence.
  initial
  begin
    do_reset;
    chk({psel, nsel, bypass, powered, rj50, rj60}, 12'h01B);
    rd_all;
    wr(4'h5, 8'hA5);
    repeat (4) chan(5);
    for (int e = 0; e < 2; e++)
      for (int g = 0; g < 8; g++)
      begin
        wr(`ADDR_GAIN, {2'b00, e[0], 2'b00, g[2:0]});
        chk({powered, bypass}, {e[0], !e[0]});
        if (e == 1)
          chk(again, (g > 5) ? 5 : g);
      end
    for (int r = 0; r < 7; r++)
    begin
      wr(`ADDR_RATE, r[7:0]);
      chk({rj50, rj60}, (r == 3 || r == 5) ? 2'b10 : (r == 6) ? 2'b01 : 2'b11);
    end
    wr(`ADDR_RATE, 8'h44);
    chk(ext_sel, 1'b1);
    chan(9);
    wr(`ADDR_RATE, 8'h04);
    chk(ext_sel, 1'b0);
    for (int m = 0; m < 5; m++)
    begin
      wr(`ADDR_MONITOR, {4'h0, m[0], m[2:0]});
      chk({burn, mon}, {m[0], m[2:0]});
    end
    rnd = lfsr(rnd);
    wr(`ADDR_EXC_ROUTE, rnd[7:0]);
    wr(`ADDR_BIAS, {1'b0, rnd[14:8]});
    wr(`ADDR_GPIO, rnd[23:16]);
    chk({exc2, exc1}, rnd[7:0]);
    chk(bias, rnd[14:8]);
    chk({gen, gout}, rnd[23:16]);
    rd_all;
    start_pin = 1'b1;
    repeat (8) @(negedge clk_i);
    chk(run, 1'b1);
    start_pin = 1'b0;
    wr(`ADDR_GAIN, 8'h26);
    fill(1);
    chk({q.size() == 16, ready, pin}, 3'b100);
    drain(1'b0);
    repeat (4) @(negedge clk_i);
    chk(pin, 1'b1);
    wr(`ADDR_GAIN, 8'h27);
    fill(2);
    drain(1'b0);
    do_reset;
    wr(`ADDR_RATE, 8'h24, 1'b1);
    host_u.xfer({16'h0, `CMD_START, 6'h0}, 8, 1'b1, rx);
    chk(run, 1'b1);
    fill(0);
    chk({q.size() == 1, run}, 2'b10);
    drain(1'b1);
    wrap_up;
  end
endmodule
bind afe_ctrl afe_ctrl_checker chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .raw_valid_i(raw_valid_i),
  .raw_ready_o(raw_ready_o), .conv_run_o(conv_run_o), .dout_oe_n_o(dout_oe_n_o),
  .data_out_ready_pin_o(data_out_ready_pin_o), .mid_supply_tie_o(mid_supply_tie_o),
  .positive_channel_sel_o(positive_channel_sel_o), .monitor_sel_o(monitor_sel_o),
  .negative_channel_sel_o(negative_channel_sel_o), .amp_powered_o(amp_powered_o),
  .amp_bypass_o(amp_bypass_o), .amp_analog_gain_o(amp_analog_gain_o));

// ===== verif/afe_host_model.sv
`timescale 1ns/10ps
// Serial host that frames commands and collects the shared output pin.
module afe_host_model (
  // Clock
  input wire clk_i,
  // Serial pins
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o,
  input wire pin_i
);
  // Idle levels: the serial clock stands low and chip select is released.
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end
  // Shifts n bits MSB first; the pin is sampled just before each rising edge.
  task automatic xfer(input logic [23:0] tx, input int n, input bit hold,
    output logic [23:0] rx);
    rx = 24'h0;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      rx = {rx[22:0], pin_i};
      din_o = tx[n-1-i];
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
      repeat (4) @(negedge clk_i);
    end
    din_o = ~din_o;
    repeat (4) @(negedge clk_i);
    if (!hold)
      cs_n_o = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask
endmodule
